// ===== pkg/lse_pkg.sv
package lse_pkg;

   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned MS_PER_S      = 1000;
   localparam int unsigned MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
   localparam int unsigned NUM_ENG       = 3;
   localparam int unsigned PROG_DEPTH    = 16;

   // register map
   localparam logic [7:0] ADDR_ENABLE   = 8'h00;
   localparam logic [7:0] ADDR_DUTY0    = 8'h02;
   localparam logic [7:0] ADDR_PC0      = 8'h09;
   localparam logic [7:0] ADDR_STATUS   = 8'h0C;
   localparam logic [7:0] ADDR_PROG0    = 8'h40;
   localparam logic [7:0] ADDR_PROG_END = 8'hA0;

   // exec mode field of engine i sits at EXEC_LSB0 - EXEC_STRIDE*i
   localparam int unsigned EXEC_LSB0   = 4;
   localparam int unsigned EXEC_STRIDE = 2;
   localparam int unsigned TRIG_EXT    = 3;

   // instruction argument fields
   localparam int unsigned RAMP_DOWN_BIT  = 12;
   localparam int unsigned RAMP_STEPS_LSB = 5;
   localparam int unsigned RAMP_TIME_LSB  = 0;
   localparam int unsigned RAMP_UNIT_SH   = 5;
   localparam int unsigned BR_COUNT_LSB   = 7;
   localparam int unsigned TRIG_WAIT_LSB  = 4;
   localparam int unsigned END_RST_BIT    = 1;
   localparam int unsigned END_INT_BIT    = 0;

   localparam logic [7:0] LEVEL_MAX = 8'hFF;
   localparam logic [7:0] LEVEL_MIN = 8'h00;

   typedef enum logic [1:0] {
      MODE_HOLD  = 2'b00,
      MODE_STEP  = 2'b01,
      MODE_RUN   = 2'b10,
      MODE_HOLD2 = 2'b11
   } lse_mode_t;

   typedef enum logic [2:0] {
      OP_RAMP   = 3'b000,
      OP_WAIT   = 3'b001,
      OP_BRANCH = 3'b010,
      OP_SETPWM = 3'b011,
      OP_START  = 3'b100,
      OP_TRIG   = 3'b101,
      OP_END    = 3'b110,
      OP_NONE   = 3'b111
   } lse_op_t;

   typedef struct packed {
      lse_op_t     op;
      logic [12:0] arg;
   } lse_instr_t;

   typedef struct packed {
      logic [3:0] pc;
      logic [5:0] loops;
      logic [7:0] level;
      logic [9:0] tmr;
      logic [6:0] steps;
      logic       busy;
      logic [3:0] pend;
   } lse_eng_t;

   typedef struct packed {
      lse_eng_t [NUM_ENG-1:0] eng;
      logic [7:0]             enable;
      logic [NUM_ENG-1:0]     status;
      logic                   int_b;
      logic [2:0]             ext_sync;
      logic                   ext_out;
      logic [15:0]            ms_cnt;
      logic                   ms_tick;
      logic [7:0]             rdata;
   } lse_state_t;

endpackage : lse_pkg

// ===== logic/lse_top.sv
// Behaviour
// R1: a ramp moves the level from its present value through a signed step count (2 to 128) over the set duration; code gives 1 to 128.
// R2: a wait halts the program for 1 to 999 ms and then goes on with the next instruction.
// R3: a branch loads a target step into the program counter, repeating count times, zero meaning forever.
// R4: a set-level instruction loads the 8-bit level at once.
// R5: a start instruction clears the program counter and runs on from the first instruction.
// R6: a trigger can wait for and/or send a trigger to red, green, blue or external, stalling while waiting.
// R7: one trigger instruction can send to several channels at once and also wait on another.
// R8: an end instruction stops the engine and may raise the interrupt pin, reset the counter, or both.
// R9: three independent engines run their own programs for red, green and blue.
// R10: the red exec-mode field is bits 5:4 of the enable register at address zero, host readable and writable.
// R11: a ramp changes the level by one per step, with steps evenly spaced over the duration.
module lse_top
   import lse_pkg::*;
#(
   parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
)(
   input  wire logic                      clk,
   input  wire logic                      rst_b,
   input  wire logic [7:0]                addr,
   input  wire logic [7:0]                wdata,
   input  wire logic                      we,
   input  wire logic                      re,
   output logic      [7:0]                rdata,
   input  wire logic                      trig_ext_in,
   output logic                           trig_ext_out,
   output logic                           int_b,
   output logic      [NUM_ENG-1:0][7:0]   pwm
);

   ////////////////////////////////////////////////////////////////////////////
   // program store, one section per engine

   logic [15:0] prog_q [NUM_ENG][PROG_DEPTH];
   logic [7:0]  poff;
   logic        prog_hit;
   logic [1:0]  pe;
   logic [3:0]  ps;
   logic        pb;

   assign poff     = addr - ADDR_PROG0;
   assign prog_hit = (addr >= ADDR_PROG0) && (addr < ADDR_PROG_END);
   assign pe       = poff[6:5];
   assign ps       = poff[4:1];
   assign pb       = poff[0];

   // no reset on the store: software loads it before running an engine
   always_ff @(posedge clk)
   begin
      if (we && prog_hit)
      begin
         if (pb)
            prog_q[pe][ps][7:0] <= wdata;
         else
            prog_q[pe][ps][15:8] <= wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // engine state

   lse_state_t s_q;
   lse_state_t s_d;

   function automatic int unsigned exec_lsb(input int unsigned i);
      exec_lsb = EXEC_LSB0 - EXEC_STRIDE * i;
   endfunction : exec_lsb

   function automatic logic [9:0] ramp_reload(input lse_instr_t ins);
      logic [4:0] f;
      f = ins.arg[RAMP_TIME_LSB +: 5];
      // one unit is 32 ms, so the longest step stays under one second
      ramp_reload = (f == 5'h00) ? 10'h001 : {f, 5'h00};
   endfunction : ramp_reload

   always_comb
   begin
      lse_instr_t          ins;
      logic                adv;
      logic                done;
      logic                ext_edge;
      logic [1:0]          md;
      logic [9:0]          wt;
      logic [5:0]          cnt;
      logic [3:0]          wm;
      logic [3:0]          snd [NUM_ENG];
      ins      = '0;
      adv      = 1'b0;
      done     = 1'b0;
      md       = 2'b00;
      wt       = 10'h000;
      cnt      = 6'h00;
      wm       = 4'h0;
      snd      = '{default: 4'h0};
      s_d      = s_q;
      ext_edge = s_q.ext_sync[1] & ~s_q.ext_sync[2];

      s_d.ext_sync = {s_q.ext_sync[1:0], trig_ext_in};
      s_d.ext_out  = 1'b0;
      s_d.rdata    = 8'h00;
      s_d.ms_tick  = 1'b0;
      if (s_q.ms_cnt == 16'(MS_CYCLES - 1))
      begin
         s_d.ms_cnt  = 16'h0000;
         s_d.ms_tick = 1'b1;
      end
      else
         s_d.ms_cnt = s_q.ms_cnt + 16'h0001;

      // write-one-to-clear first, so an engine setting a flag now wins
      if (we && addr == ADDR_STATUS)
         s_d.status = s_q.status & ~wdata[NUM_ENG-1:0];

      for (int unsigned i = 0; i < NUM_ENG; i++)
      begin
         snd[i] = 4'h0;
         adv    = 1'b0;
         done   = 1'b0;
         ins    = lse_instr_t'(prog_q[i][s_q.eng[i].pc]);
         md     = s_q.enable[exec_lsb(i) +: 2];
         if (md == MODE_RUN || md == MODE_STEP) // [R9]
         begin
            case (ins.op)
               OP_RAMP:
               begin
                  if (!s_q.eng[i].busy)
                  begin
                     s_d.eng[i].busy  = 1'b1;
                     s_d.eng[i].steps = ins.arg[RAMP_STEPS_LSB +: 7]; // [R1]
                     s_d.eng[i].tmr   = ramp_reload(ins);
                  end
                  else if (s_q.ms_tick)
                  begin
                     if (s_q.eng[i].tmr > 10'h001)
                        s_d.eng[i].tmr = s_q.eng[i].tmr - 10'h001;
                     else
                     begin
                        // one unit per step, saturating at the rails
                        if (ins.arg[RAMP_DOWN_BIT])
                        begin
                           if (s_q.eng[i].level != LEVEL_MIN)
                              s_d.eng[i].level = s_q.eng[i].level - 8'h01; // [R11]
                        end
                        else if (s_q.eng[i].level != LEVEL_MAX)
                           s_d.eng[i].level = s_q.eng[i].level + 8'h01; // [R11]
                        if (s_q.eng[i].steps == 7'h00)
                        begin
                           s_d.eng[i].busy = 1'b0;
                           adv             = 1'b1; // [R1]
                        end
                        else
                        begin
                           s_d.eng[i].steps = s_q.eng[i].steps - 7'h01;
                           s_d.eng[i].tmr   = ramp_reload(ins); // [R11]
                        end
                     end
                  end
               end
               OP_WAIT:
               begin
                  wt = ins.arg[9:0];
                  if (!s_q.eng[i].busy)
                  begin
                     s_d.eng[i].busy = 1'b1;
                     s_d.eng[i].tmr  = (wt == 10'h000) ? 10'h001 : wt; // [R2]
                  end
                  else if (s_q.ms_tick)
                  begin
                     if (s_q.eng[i].tmr > 10'h001)
                        s_d.eng[i].tmr = s_q.eng[i].tmr - 10'h001;
                     else
                     begin
                        s_d.eng[i].busy = 1'b0;
                        adv             = 1'b1; // [R2]
                     end
                  end
               end
               OP_BRANCH:
               begin
                  // one loop counter per engine: nested counted loops are not supported
                  cnt  = ins.arg[BR_COUNT_LSB +: 6];
                  done = 1'b1;
                  if (cnt == 6'h00)
                     s_d.eng[i].pc = ins.arg[3:0]; // [R3]
                  else if (s_q.eng[i].loops == cnt)
                  begin
                     s_d.eng[i].loops = 6'h00;
                     adv              = 1'b1; // [R3]
                  end
                  else
                  begin
                     s_d.eng[i].loops = s_q.eng[i].loops + 6'h01;
                     s_d.eng[i].pc    = ins.arg[3:0]; // [R3]
                  end
               end
               OP_SETPWM:
               begin
                  s_d.eng[i].level = ins.arg[7:0]; // [R4]
                  adv              = 1'b1;
               end
               OP_START:
               begin
                  s_d.eng[i].pc    = 4'h0; // [R5]
                  s_d.eng[i].loops = 6'h00;
                  done             = 1'b1;
               end
               OP_TRIG:
               begin
                  wm = ins.arg[TRIG_WAIT_LSB +: 4];
                  if (!s_q.eng[i].busy)
                  begin
                     snd[i] = ins.arg[3:0]; // [R7]
                     if (wm == 4'h0)
                        adv = 1'b1;
                     else
                        s_d.eng[i].busy = 1'b1; // [R6]
                  end
                  else if ((s_q.eng[i].pend & wm) == wm)
                  begin
                     s_d.eng[i].pend = s_q.eng[i].pend & ~wm; // [R6]
                     s_d.eng[i].busy = 1'b0;
                     adv             = 1'b1;
                  end
               end
               OP_END:
               begin
                  s_d.enable[exec_lsb(i) +: 2] = MODE_HOLD; // [R8]
                  if (ins.arg[END_INT_BIT])
                     s_d.status[i] = 1'b1; // [R8]
                  if (ins.arg[END_RST_BIT])
                  begin
                     s_d.eng[i].pc    = 4'h0; // [R8]
                     s_d.eng[i].loops = 6'h00;
                  end
               end
               default:
                  s_d.enable[exec_lsb(i) +: 2] = MODE_HOLD;
            endcase
            if (adv)
               s_d.eng[i].pc = s_q.eng[i].pc + 4'h1;
            if ((adv || done) && md == MODE_STEP)
               s_d.enable[exec_lsb(i) +: 2] = MODE_HOLD;
         end
      end

      // deliver triggers after the waits consumed theirs, so arrivals are kept
      for (int unsigned d = 0; d < NUM_ENG; d++)
      begin
         for (int unsigned src = 0; src < NUM_ENG; src++)
         begin
            if (snd[src][d])
               s_d.eng[d].pend[src] = 1'b1; // [R6]
         end
         if (ext_edge)
            s_d.eng[d].pend[TRIG_EXT] = 1'b1; // [R6]
      end
      for (int unsigned src = 0; src < NUM_ENG; src++)
      begin
         if (snd[src][TRIG_EXT])
            s_d.ext_out = 1'b1; // [R7]
      end

      ////////////////////////////////////////////////////////////////////////
      // host writes override engine updates of the same field

      if (we)
      begin
         if (addr == ADDR_ENABLE)
            s_d.enable = wdata; // [R10]
         for (int unsigned i = 0; i < NUM_ENG; i++)
         begin
            if (addr == ADDR_DUTY0 + 8'(i))
               s_d.eng[i].level = wdata;
            if (addr == ADDR_PC0 + 8'(i))
            begin
               s_d.eng[i].pc    = wdata[3:0];
               s_d.eng[i].busy  = 1'b0;
               s_d.eng[i].loops = 6'h00;
            end
         end
      end

      if (re)
      begin
         if (addr == ADDR_ENABLE)
            s_d.rdata = s_q.enable; // [R10]
         else if (addr == ADDR_STATUS)
            s_d.rdata = {5'h00, s_q.status};
         else if (prog_hit && pe != 2'b11)
            s_d.rdata = pb ? prog_q[pe][ps][7:0] : prog_q[pe][ps][15:8];
         for (int unsigned i = 0; i < NUM_ENG; i++)
         begin
            if (addr == ADDR_DUTY0 + 8'(i))
               s_d.rdata = s_q.eng[i].level;
            if (addr == ADDR_PC0 + 8'(i))
               s_d.rdata = {4'h0, s_q.eng[i].pc};
         end
      end

      s_d.int_b = ~|s_d.status; // [R8]
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_q       <= '0;
         s_q.int_b <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from the state register

   assign rdata        = s_q.rdata;
   assign trig_ext_out = s_q.ext_out;
   assign int_b        = s_q.int_b;

   for (genvar g = 0; g < NUM_ENG; g++)
   begin : g_pwm
      assign pwm[g] = s_q.eng[g].level;
   end

endmodule : lse_top

// ===== testbench/lse_chk.sv
module lse_chk
   import lse_pkg::*;
#(
   parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
)(
   input wire logic                    clk,
   input wire logic                    rst_b,
   input wire logic [7:0]              addr,
   input wire logic [7:0]              wdata,
   input wire logic                    we,
   input wire logic                    re,
   input wire logic [7:0]              rdata,
   input wire logic                    trig_ext_in,
   input wire logic                    trig_ext_out,
   input wire logic                    int_b,
   input wire logic [NUM_ENG-1:0][7:0] pwm
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////
   chk_rdata_idle: assert property (!re |=> rdata == 8'h00)
      else $error("read data not zero outside a read");
   // all-hold modes only, so no engine can clear its field meanwhile
   chk_mode_readback: assert property (we && addr == ADDR_ENABLE && wdata[5] == wdata[4]
      && wdata[3] == wdata[2] && wdata[1] == wdata[0] ##2 re && addr == ADDR_ENABLE |=> rdata == $past(wdata, 3))
      else $error("enable readback differs from write");
   chk_unmapped_zero: assert property (re && (addr == 8'h01 || addr >= ADDR_PROG_END) |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_red_level: assert property (we && addr == ADDR_DUTY0 |=> pwm[0] == $past(wdata))
      else $error("red level write lost");
   chk_green_level: assert property (we && addr == ADDR_DUTY0 + 8'h01 |=> pwm[1] == $past(wdata))
      else $error("green level write lost");
   chk_blue_level: assert property (we && addr == ADDR_DUTY0 + 8'h02 |=> pwm[2] == $past(wdata))
      else $error("blue level write lost");
   chk_ext_pulse: assert property (trig_ext_out |=> !trig_ext_out)
      else $error("external trigger pulse too long");
   chk_reset_quiet: assert property ($rose(rst_b) |-> pwm == '0 && int_b && !trig_ext_out)
      else $error("outputs not quiet after reset");
endmodule : lse_chk

bind lse_top lse_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
   .we(we), .re(re), .rdata(rdata), .trig_ext_in(trig_ext_in), .trig_ext_out(trig_ext_out), .int_b(int_b),
   .pwm(pwm));

// ===== testbench/lse_host.sv
module lse_host
   import lse_pkg::*;
(
   input  wire logic       clk,
   output logic      [7:0] addr,
   output logic      [7:0] wdata,
   output logic            we,
   output logic            re,
   input  wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      addr  = 8'h00;
      wdata = 8'h00;
      we    = 1'b0;
      re    = 1'b0;
   end
   ////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      we    <= 1'b1;
      @(posedge clk);
      we    <= 1'b0;
   endtask : wr
   // data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      re   <= 1'b1;
      @(posedge clk);
      re   <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task automatic load(input int e, input int s, input logic [15:0] w);
      logic [7:0] a;
      a = ADDR_PROG0 + 8'(e * 32 + s * 2);
      wr(a, w[15:8]);
      wr(a + 8'h01, w[7:0]);
   endtask : load
endmodule : lse_host

// ===== testbench/led_sequence_engine_bench.sv
module led_sequence_engine_bench
   import lse_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned MS = 4; // short ms keeps ramps and waits brief
   logic                    clk;
   logic                    rst_b;
   logic                    we;
   logic                    re;
   logic                    trig_ext_in;
   logic                    trig_ext_out;
   logic                    int_b;
   logic                    cnt_on = 1'b0;
   logic [7:0]              addr;
   logic [7:0]              wdata;
   logic [7:0]              rdata;
   logic [7:0]              d;
   logic [7:0]              prev;
   logic [NUM_ENG-1:0][7:0] pwm;
   int                      error_cnt = 0;
   int                      n_tests = 0;
   int                      cyc = 0;
   int                      n_chg = 0;
   int                      n_ext = 0;
   int                      n_up = 0;
   int                      gap = 0;
   int                      max_gap = 0;
   // unused tail steps hold an end so a stray jump stops
   logic [15:0] prog [3][7] = '{'{16'h6010, 16'h0040, 16'h1020, 16'h2002, 16'h4102, 16'hA00A, 16'hC001},
                                '{16'hA010, 16'h6055, 16'hA080, 16'hC003, 16'hC000, 16'hC000, 16'hC000},
                                '{16'h0000, 16'h8000, 16'hC000, 16'hC000, 16'hC000, 16'hC000, 16'hC000}};
   lse_top #(.MS_CYCLES(MS)) i_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .we(we), .re(re),
      .rdata(rdata), .trig_ext_in(trig_ext_in), .trig_ext_out(trig_ext_out), .int_b(int_b), .pwm(pwm));
   lse_host i_host (.clk(clk), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata));
   ////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      if (error_cnt == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // falling edge sees settled registered outputs
   always @(negedge clk)
   begin
      cyc++;
      prev <= pwm[0];
      if (cnt_on)
         gap++;
      // longest quiet stretch of red spans the 2 ms wait plus one ramp step
      if (cnt_on && pwm[0] !== prev)
      begin
         n_chg++;
         if (pwm[0] > prev)
            n_up++;
         if (gap > max_gap)
            max_gap = gap;
         gap = 0;
      end
      if (trig_ext_out === 1'b1)
         n_ext++;
      if (cyc == 6000)
      begin
         error_cnt++;
         final_report();
      end
   end
   initial
   begin
      trig_ext_in = 1'b0;
      rst_b       = 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      i_host.rd(ADDR_ENABLE, d);
      check(d, 8'h00);
      i_host.wr(ADDR_ENABLE, 8'h30);
      i_host.rd(ADDR_ENABLE, d);
      check(d, 8'h30);
      i_host.rd(8'h01, d);
      check(d, 8'h00);
      i_host.wr(ADDR_DUTY0, 8'hAA);
      i_host.wr(ADDR_DUTY0 + 8'h01, 8'h5A);
      i_host.wr(ADDR_DUTY0 + 8'h02, 8'hA5);
      i_host.rd(ADDR_DUTY0, d);
      check(d, 8'hAA);
      check(pwm[2], 8'hA5);
      for (int e = 0; e < 3; e++)
         for (int s = 0; s < 7; s++)
            i_host.load(e, s, prog[e][s]);
      cnt_on = 1'b1;
      i_host.wr(ADDR_ENABLE, 8'h2A);
      for (int i = 0; i < 800 && int_b !== 1'b0; i++)
         @(posedge clk);
      repeat (20) @(posedge clk);
      check(pwm[0], 8'h0D);
      check(8'(n_chg), 8'h0A);
      check(8'(n_up), 8'h03);
      check(8'(max_gap), 8'h0C);
      check(pwm[1], 8'h55);
      check(8'(n_ext), 8'h01);
      check({7'h00, int_b}, 8'h00);
      i_host.rd(ADDR_STATUS, d);
      check(d & 8'h07, 8'h01);
      @(posedge clk);
      trig_ext_in <= 1'b1;
      repeat (3) @(posedge clk);
      trig_ext_in <= 1'b0;
      repeat (10) @(posedge clk);
      i_host.rd(ADDR_STATUS, d);
      check(d & 8'h07, 8'h03);
      i_host.rd(ADDR_ENABLE, d);
      check(d, 8'h02);
      i_host.rd(ADDR_PC0, d);
      check(d & 8'h0F, 8'h06);
      i_host.rd(ADDR_PC0 + 8'h01, d);
      check(d & 8'h0F, 8'h00);
      check({7'h00, pwm[2] > 8'hA9}, 8'h01);
      // step mode: blue runs one ramp step, then its field drops back to hold
      i_host.wr(ADDR_ENABLE, 8'h00);
      i_host.wr(ADDR_PC0 + 8'h02, 8'h00);
      i_host.wr(ADDR_ENABLE, 8'h01);
      repeat (10) @(posedge clk);
      i_host.rd(ADDR_ENABLE, d);
      check(d, 8'h00);
      i_host.rd(ADDR_PC0 + 8'h02, d);
      check(d & 8'h0F, 8'h01);
      i_host.wr(ADDR_STATUS, 8'h03);
      repeat (2) @(posedge clk);
      check({7'h00, int_b}, 8'h01);
      final_report();
   end
endmodule : led_sequence_engine_bench
